// *** src/hbw_pkg.sv ***
// What this block does
// - Hold busy output low after reset while loader and protection downloads run.
// - Release busy only when both download steps have finished.
// - Word access on a 16-bit bus is the default; byte mode also offered.
// - In byte mode upper data lines are weakly pulled up, may float.
// - Byte mode steers both even and odd address bytes onto the low buffer lane.
// - Boot block answers reads correctly in both byte and word mode.
// - Flash data area is a 16-bit port whatever the host width.
// - Word mode with address bit zero low moves both lanes; bit high illegal.
// - Byte mode, address bit zero low: even byte on low lane.
// - Byte mode, address bit zero high: odd byte on low lane.
// - Only the low thirteen address bits are decoded.
package hbw_pkg;
    localparam int ADDR_W      = 13;
    localparam int DATA_W      = 16;
    localparam int BYTE_W      = 8;
    localparam int BOOT_DEPTH  = 1024;
    localparam int PROT_DEPTH  = 16;
    localparam int LANE_SEL_B  = 0;
    localparam logic [ADDR_W-1:0] BOOT_BASE  = 13'h0000;
    localparam logic [ADDR_W-1:0] FLASH_BASE = 13'h0800;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
    localparam logic [BYTE_W-1:0] PULLUP_BYTE = 8'hff;
    typedef enum logic [1:0] {
        HBW_IDLE  = 2'b00,
        HBW_LOAD  = 2'b01,
        HBW_PROT  = 2'b10,
        HBW_READY = 2'b11
    } hbw_state_t;
endpackage : hbw_pkg

// *** src/hbw_lane_steer.sv ***
`timescale 1ns/1ps
module hbw_lane_steer
    import hbw_pkg::*;
(
    input  wire logic              word_mode_i,
    input  wire logic              addr0_i,
    input  wire logic [DATA_W-1:0] mem_word_i,
    output logic      [DATA_W-1:0] host_data_o,
    output logic      [1:0]        lane_oe_n_o
);
    // Pick lanes from width select and address bit zero
    always_comb begin
        host_data_o = mem_word_i;
        lane_oe_n_o = 2'b00;
        if (!word_mode_i) begin
            lane_oe_n_o = 2'b10;
            if (addr0_i) begin
                host_data_o = {PULLUP_BYTE, mem_word_i[DATA_W-1:BYTE_W]};
            end else begin
                host_data_o = {PULLUP_BYTE, mem_word_i[BYTE_W-1:0]};
            end
        end
    end
endmodule : hbw_lane_steer

// *** src/hbw_sync.sv ***
`timescale 1ns/1ps
module hbw_sync (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic en_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;
    // Two stages; first stage read only by the second
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else if (en_i) begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule : hbw_sync

// *** src/hbw_host_port.sv ***
`timescale 1ns/1ps
module hbw_host_port
    import hbw_pkg::*;
#(
    parameter int LOAD_WORDS = BOOT_DEPTH,
    parameter int PROT_WORDS = PROT_DEPTH
) (
    input  wire logic              ref_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              clk_en_i,
    input  wire logic              power_on_reset_n_i,
    input  wire logic              width_sel_i,
    input  wire logic [ADDR_W-1:0] host_addr_i,
    input  wire logic              host_rd_i,
    input  wire logic              host_wr_i,
    input  wire logic [DATA_W-1:0] host_wdata_i,
    input  wire logic              src_valid_i,
    input  wire logic [DATA_W-1:0] src_data_i,
    output logic                   src_ready_o,
    output logic                   busy_n_o,
    output logic      [DATA_W-1:0] host_rdata_o,
    output logic      [1:0]        lane_oe_n_o,
    output logic                   illegal_o,
    output logic      [DATA_W-1:0] flash_wdata_o,
    output logic                   flash_wr_o
);
    logic [DATA_W-1:0] boot_mem [BOOT_DEPTH];
    logic [DATA_W-1:0] prot_mem [PROT_DEPTH];
    hbw_state_t        state;
    logic [15:0]       cnt;
    logic              rst_n_s;
    logic              rst_n_q;
    logic              word_s;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] steer_data;
    logic [1:0]        steer_oe_n;
    logic              rd_q;
    logic [1:0]        oe_q;
    logic              is_boot;

    // Width select is a strap pin, so resynchronise it
    hbw_sync u_rst_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (clk_en_i),
        .d_i       (power_on_reset_n_i),
        .q_o       (rst_n_s)
    );
    hbw_sync u_wid_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (clk_en_i),
        .d_i       (width_sel_i),
        .q_o       (word_s)
    );

    // Release edge of the host reset pin starts init
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_n_q <= 1'b0;
        end else if (clk_en_i) begin
            rst_n_q <= rst_n_s;
        end
    end

    // Download sequencer: loader first, then protection words
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= HBW_IDLE;
            cnt   <= 16'h0000;
        end else if (clk_en_i) begin
            if (!rst_n_s) begin
                state <= HBW_IDLE;
                cnt   <= 16'h0000;
            end else begin
                unique case (state)
                    HBW_IDLE: begin
                        if (!rst_n_q) begin
                            state <= HBW_LOAD;
                        end
                    end
                    HBW_LOAD: begin
                        if (src_valid_i) begin
                            if (cnt == 16'(LOAD_WORDS - 1)) begin
                                state <= HBW_PROT;
                                cnt   <= 16'h0000;
                            end else begin
                                cnt <= cnt + 16'h0001;
                            end
                        end
                    end
                    HBW_PROT: begin
                        if (src_valid_i) begin
                            if (cnt == 16'(PROT_WORDS - 1)) begin
                                state <= HBW_READY;
                                cnt   <= 16'h0000;
                            end else begin
                                cnt <= cnt + 16'h0001;
                            end
                        end
                    end
                    HBW_READY: begin
                        state <= HBW_READY;
                    end
                endcase
            end
        end
    end

    // Source is only taken while downloading; stalls otherwise
    assign src_ready_o = rst_n_s && ((state == HBW_LOAD) || (state == HBW_PROT));

    // Download storage; only the download source writes it, never the host
    always_ff @(posedge ref_clk_i) begin
        if (clk_en_i) begin
            if (src_valid_i && src_ready_o && state == HBW_LOAD) begin
                boot_mem[cnt[$clog2(BOOT_DEPTH)-1:0]] <= src_data_i;
            end
            if (src_valid_i && src_ready_o && state == HBW_PROT) begin
                prot_mem[cnt[$clog2(PROT_DEPTH)-1:0]] <= src_data_i;
            end
        end
    end

    // Upper address bits beyond thirteen never reach this port
    assign is_boot = (host_addr_i < FLASH_BASE);

    // Busy output: low until both downloads are done
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_n_o <= 1'b0;
        end else if (clk_en_i) begin
            busy_n_o <= (state == HBW_READY) && rst_n_s;
        end
    end

    // Full word fetched from boot block or, above it, from the protection words; steering picks a byte
    always_comb begin
        if (is_boot) begin
            rd_word = boot_mem[host_addr_i[$clog2(BOOT_DEPTH):1]];
        end else begin
            rd_word = prot_mem[host_addr_i[$clog2(PROT_DEPTH):1]];
        end
    end

    hbw_lane_steer u_steer (
        .word_mode_i (word_s),
        .addr0_i     (host_addr_i[LANE_SEL_B]),
        .mem_word_i  (rd_word),
        .host_data_o (steer_data),
        .lane_oe_n_o (steer_oe_n)
    );

    // Answer captured at the strobe edge so data and lanes stand in the next cycle.
    // Accesses before ready are ignored; host must wait on busy.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            host_rdata_o <= ERASED_WORD;
            rd_q         <= 1'b0;
            oe_q         <= 2'b11;
        end else if (clk_en_i) begin
            rd_q <= host_rd_i && busy_n_o;
            if (host_rd_i && busy_n_o) begin
                host_rdata_o <= steer_data;                          // Held until next read
                oe_q         <= steer_oe_n;
            end
        end
    end
    assign lane_oe_n_o = rd_q ? oe_q : 2'b11;

    // Flag odd address in word mode; flash write forwards a 16-bit word
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            illegal_o     <= 1'b0;
            flash_wr_o    <= 1'b0;
            flash_wdata_o <= ERASED_WORD;
        end else if (clk_en_i) begin
            illegal_o  <= (host_rd_i || host_wr_i) && word_s && busy_n_o
                          && host_addr_i[LANE_SEL_B];
            flash_wr_o <= host_wr_i && busy_n_o && !is_boot;
            if (host_wr_i && busy_n_o) begin
                // Byte writes replicate onto both halves of the word
                flash_wdata_o <= word_s ? host_wdata_i
                               : {host_wdata_i[BYTE_W-1:0], host_wdata_i[BYTE_W-1:0]};
            end
        end
    end
endmodule : hbw_host_port

// *** verification/hbw_host_port_assertions.sv ***
`timescale 1ns/1ps
module hbw_host_port_checker
    import hbw_pkg::*;
#(
    parameter int LOAD_WORDS = BOOT_DEPTH,
    parameter int PROT_WORDS = PROT_DEPTH
) (
    input wire logic              ref_clk_i,
    input wire logic              sys_rst_i,
    input wire logic              power_on_reset_n_i,
    input wire logic              width_sel_i,
    input wire logic [ADDR_W-1:0] host_addr_i,
    input wire logic              host_rd_i,
    input wire logic              host_wr_i,
    input wire logic [DATA_W-1:0] host_wdata_i,
    input wire logic              src_valid_i,
    input wire logic              src_ready_o,
    input wire logic              busy_n_o,
    input wire logic [DATA_W-1:0] host_rdata_o,
    input wire logic [1:0]        lane_oe_n_o,
    input wire logic              illegal_o,
    input wire logic [DATA_W-1:0] flash_wdata_o,
    input wire logic              flash_wr_o
);
    logic [2:0] ws_hist;
    logic       wide, narrow, take_rd, hit_odd;
    // Strap history: lane checks wait until the synchronised mode has settled
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            ws_hist <= 3'b010;
        else
            ws_hist <= {ws_hist[1:0], width_sel_i};
    end
    // Qualified host strobes
    assign wide    = (&ws_hist) && width_sel_i;
    assign narrow  = !(|ws_hist) && !width_sel_i;
    assign take_rd = host_rd_i && busy_n_o;
    assign hit_odd = (host_rd_i || host_wr_i) && busy_n_o && host_addr_i[0];
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_busy_on_por: assert property (!power_on_reset_n_i |-> ##4 !busy_n_o)
        else $error("busy not asserted after host reset");
    a_busy_after_load: assert property (src_valid_i && src_ready_o |=> !busy_n_o)
        else $error("busy released while download still running");
    a_idle_no_lanes: assert property (!take_rd |=> lane_oe_n_o == 2'b11)
        else $error("data lanes driven without a taken read");
    a_word_lanes: assert property (take_rd && wide && !host_addr_i[0] |=> lane_oe_n_o == 2'b00)
        else $error("word read did not drive both lanes");
    a_byte_lanes: assert property (take_rd && narrow |=>
        lane_oe_n_o == 2'b10 && host_rdata_o[15:8] == PULLUP_BYTE)
        else $error("byte read drove or corrupted the upper lane");
    a_rdata_holds: assert property (!take_rd |=> $stable(host_rdata_o))
        else $error("read data changed without a read");
    a_illegal_flag: assert property (hit_odd && wide |=> illegal_o)
        else $error("odd word access not flagged");
    a_illegal_cause: assert property (illegal_o |-> $past(hit_odd))
        else $error("illegal flag without odd access");
    a_flash_write: assert property (host_wr_i && busy_n_o && wide && !host_addr_i[0]
        && host_addr_i >= FLASH_BASE |=> flash_wr_o && flash_wdata_o == $past(host_wdata_i))
        else $error("flash write not passed on whole");
endmodule : hbw_host_port_checker

bind hbw_host_port hbw_host_port_checker #(.LOAD_WORDS(LOAD_WORDS), .PROT_WORDS(PROT_WORDS)) u_chk (
    .ref_clk_i, .sys_rst_i, .power_on_reset_n_i, .width_sel_i, .host_addr_i, .host_rd_i,
    .host_wr_i, .host_wdata_i, .src_valid_i, .src_ready_o, .busy_n_o, .host_rdata_o,
    .lane_oe_n_o, .illegal_o, .flash_wdata_o, .flash_wr_o);

// *** verification/hbw_host_model.sv ***
`timescale 1ns/1ps
module hbw_host_model
    import hbw_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              busy_n_i,
    output logic                   width_sel_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   rd_o,
    output logic                   wr_o,
    output logic      [DATA_W-1:0] wdata_o
);
    // Bus at rest in word mode
    initial begin
        width_sel_o = 1'b1;
        addr_o = '0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = '0;
    end
    // Strap change, then time for the two-stage synchroniser
    task automatic set_width(input logic word);
        @(posedge ref_clk_i);
        width_sel_o <= word;
        repeat (4) @(posedge ref_clk_i);
    endtask : set_width
    // One strobe cycle; released lines show the inverse so stale values cannot pass
    task automatic cyc(input logic write, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk_i);
        while (busy_n_i !== 1'b1) @(posedge ref_clk_i);
        rd_o <= !write;
        wr_o <= write;
        addr_o <= a;
        wdata_o <= d;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : cyc
    // Double-word host: bit zero tied low, bit one fed from host_addr_bit2
    task automatic dword_rd(input logic [ADDR_W:0] sys_addr);
        cyc(1'b0, {sys_addr[ADDR_W:2], 1'b0}, '0);
    endtask : dword_rd
endmodule : hbw_host_model

// *** verification/host_bus_width_and_init_busy_test.sv ***
`timescale 1ns/1ps
module host_bus_width_and_init_busy_test;
    import hbw_pkg::*;
    localparam int LW = 4;
    localparam int PW = 2;
    logic              ref_clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              por_n = 1'b0;
    logic              src_valid = 1'b0;
    logic [DATA_W-1:0] src_data = '0;
    logic              width_sel, host_rd, host_wr, src_ready, busy_n, illegal, flash_wr;
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_wdata, rdata, flash_wdata, exp, d;
    logic [1:0]        oe_n;
    logic [DATA_W-1:0] words [LW+PW];
    int                num_errors = 0;
    int                checked = 0;
    int                fill = 0;
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    hbw_host_port #(.LOAD_WORDS(LW), .PROT_WORDS(PW)) dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .power_on_reset_n_i(por_n), .width_sel_i(width_sel), .host_addr_i(host_addr),
        .host_rd_i(host_rd), .host_wr_i(host_wr), .host_wdata_i(host_wdata),
        .src_valid_i(src_valid), .src_data_i(src_data), .src_ready_o(src_ready),
        .busy_n_o(busy_n), .host_rdata_o(rdata), .lane_oe_n_o(oe_n), .illegal_o(illegal),
        .flash_wdata_o(flash_wdata), .flash_wr_o(flash_wr));
    hbw_host_model host (.ref_clk_i(ref_clk_i), .busy_n_i(busy_n), .width_sel_o(width_sel),
        .addr_o(host_addr), .rd_o(host_rd), .wr_o(host_wr), .wdata_o(host_wdata));
    // Download source stalls at random but holds a word until it is taken
    always @(posedge ref_clk_i) begin
        if (src_valid && src_ready) fill++;
        if (!(src_valid && !src_ready)) begin
            src_valid <= (fill < LW + PW) && ($urandom_range(1, 0) == 1);
            src_data <= words[fill % (LW + PW)];
        end
    end
    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] got);
        checked++;
        if (got !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, e, got);
        end
    endtask : cmp
    task automatic stop_test;
        $display("counts: %0d checked, %0d mismatches", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Watchdog sized well above the hundred or so cycles the tests need
    initial begin
        #(5000 * 8);
        num_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h8be1));
        for (int i = 0; i < LW + PW; i++) words[i] = 16'($urandom);
        repeat (5) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        por_n <= 1'b1;
        #1 cmp("busy_n_o", 16'h0, {15'h0, busy_n});
        for (int i = 0; i < 300 && busy_n !== 1'b1; i++) @(posedge ref_clk_i);
        cmp("words before ready", 16'(LW + PW), 16'(fill));
        $display("test init done");
        for (int m = 1; m >= 0; m--) begin
            host.set_width(m[0]);
            for (int i = 0; i < 2 * LW; i++) begin
                if (m == 1 && i[0]) continue;
                if (m == 1) host.dword_rd(14'(2 * i));
                else host.cyc(1'b0, 13'(i), '0);
                #1 exp = i[0] ? words[i/2][15:8] : words[i/2][7:0];
                if (m == 0) exp[15:8] = PULLUP_BYTE;
                else exp = words[i/2];
                cmp("host_rdata_o", exp, rdata);
                cmp("lane_oe_n_o", m ? 16'h0 : 16'h2, {14'h0, oe_n});
            end
            $display("test reads in mode %0d done", m);
        end
        host.set_width(1'b1);
        host.cyc(1'b0, 13'h1, '0);
        #1 cmp("illegal_o", 16'h1, {15'h0, illegal});
        d = 16'($urandom);
        host.cyc(1'b1, FLASH_BASE, d);
        #1 cmp("flash_wr_o", 16'h1, {15'h0, flash_wr});
        cmp("flash_wdata_o", d, flash_wdata);
        host.cyc(1'b1, 13'h2, ~d);
        #1 cmp("flash_wr_o boot", 16'h0, {15'h0, flash_wr});
        host.cyc(1'b0, 13'h2, '0);
        #1 cmp("boot word kept", words[1], rdata);
        $display("test illegal and writes done");
        stop_test();
    end
endmodule : host_bus_width_and_init_busy_test
